// ==== design/pgit_params.svh ====
// timing, interval and reset constants of the power gating interval timer
`ifndef PGIT_PARAMS_SVH
`define PGIT_PARAMS_SVH

// ------------------------------------------------------------------
// clock and oscillator base period
// ------------------------------------------------------------------
`define PGIT_CLK_PERIOD_NS 4
`define PGIT_OSC_PERIOD_NS 15625000
// half an oscillator period in clock cycles, rounded down
`define PGIT_HALF_CYCLES ((`PGIT_OSC_PERIOD_NS / `PGIT_CLK_PERIOD_NS) / 2)

// ------------------------------------------------------------------
// sequence lengths in half oscillator periods; the gate drive stays low one half longer than PGIT_GATE_HALVES
// ------------------------------------------------------------------
`define PGIT_CAL_START_HALVES 2'h1
`define PGIT_CAL_END_HALVES 2'h3
`define PGIT_GATE_HALVES 2'h3

// ------------------------------------------------------------------
// delay intervals in oscillator periods, one per strap code
// ------------------------------------------------------------------
`define PGIT_PERIODS_16S 17'h00400
`define PGIT_PERIODS_32S 17'h00800
`define PGIT_PERIODS_64S 17'h01000
`define PGIT_PERIODS_100S 17'h01900
`define PGIT_PERIODS_128S 17'h02000
`define PGIT_PERIODS_256S 17'h04000
`define PGIT_PERIODS_512S 17'h08000
`define PGIT_PERIODS_1024S 17'h10000

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define PGIT_GATE_RESET 1'b1
`define PGIT_CAL_RESET 1'b0

`endif

// ==== design/pgit_pkg.sv ====
// types shared by the power gating interval timer
package pgit_pkg;
  typedef enum logic [0:0]
  {
    PGIT_ST_COUNT = 1'b0,
    PGIT_ST_DRIVE = 1'b1
  } pgit_state_t;
endpackage : pgit_pkg

// ==== design/pgit_half_tick.sv ====
// divider that yields a one-cycle pulse every half oscillator period
module pgit_half_tick #(
  parameter int unsigned HALF_CYCLES = 2
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async clear, active low
  input wire logic restart, // realign the phase to zero
  output logic tick // one-cycle pulse per half period
);
  localparam int unsigned DW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [DW-1:0] LAST = DW'(HALF_CYCLES - 1);

  if (HALF_CYCLES < 1)
  begin : g_bad_half
    $error("HALF_CYCLES must be at least one");
  end

  logic [DW-1:0] div_q;

  // free-running count, realigned on restart so intervals start whole
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else if (restart || div_q == LAST)
      div_q <= '0;
    else
      div_q <= div_q + DW'(1);
  end

  assign tick = !restart && (div_q == LAST);
endmodule : pgit_half_tick

// ==== design/pgit_top.sv ====
// power gating interval timer: counts the selected delay, drives the gate and calibration pulse
//
// Operation
// - supply-good low while host off: counter cleared, gate drive held inactive
// - supply-good low while host on: gate drive returns high, host loses power
// - after supply returns, host powered only after the full delay counted
// - rising supply-good starts the oscillator and the interval count
// - at interval expiry gate drive goes low, then calibration pulse follows
// - calibration rises half period after gate fall, lasts one period, once
// - done pulse clears counter, raises gate drive, forces calibration low
// - done during calibration high cuts the pulse, both outputs to defaults
// - without done, gate drive held low two periods then released
// - supply-good fall stops oscillator, asynchronously resets both outputs
// - straps select 16,32,64,100,128,256,512,1024 second intervals
`include "pgit_params.svh"

module pgit_top #(
  parameter int unsigned HALF_CYCLES = `PGIT_HALF_CYCLES
) (
  input wire logic CLOCK, // 250 MHz system clock
  input wire logic RESET_N, // async reset, active low
  input wire logic SUPPLY_GOOD_IN, // supply monitor good flag, high = good
  input wire logic DONE_IN, // host completion pulse, active high
  input wire logic INTERVAL_SELECT_BIT0, // strap, interval code lsb
  input wire logic INTERVAL_SELECT_BIT1, // strap, interval code middle bit
  input wire logic INTERVAL_SELECT_BIT2, // strap, interval code msb
  output logic POWER_GATE_DRIVE_N, // power gate drive, low = host powered
  output logic CALIBRATION_PULSE_OUT // one-period calibration pulse
);
  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  localparam int CW = 17;

  if (HALF_CYCLES < 1)
  begin : g_bad_half
    $error("HALF_CYCLES must be at least one");
  end

  logic rst_n_int;
  logic tick;
  logic done_q;
  logic done_evt;
  logic [2:0] sel_q;
  logic [CW-1:0] periods;
  logic [CW:0] target_halves;
  logic [CW:0] cnt_q;
  logic [1:0] phase_q;
  pgit_pkg::pgit_state_t state_q;
  logic gate_q;
  logic cal_q;
  logic expire;
  logic drive_end;

  // supply loss acts as an async clear; the oscillator is stopped with it
  assign rst_n_int = RESET_N & SUPPLY_GOOD_IN;

  // ------------------------------------------------------------------
  // half period enable from the oscillator model
  // ------------------------------------------------------------------
  pgit_half_tick #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_half_tick (
    .clk(CLOCK),
    .rst_n(rst_n_int),
    .restart(done_evt),
    .tick(tick)
  );

  // ------------------------------------------------------------------
  // done recognition
  // ------------------------------------------------------------------
  // rising edge only, so a long done level does not stall the next interval
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      done_q <= 1'b0;
    else
      done_q <= DONE_IN;
  end

  assign done_evt = DONE_IN & ~done_q;

  // ------------------------------------------------------------------
  // strap capture and interval table
  // ------------------------------------------------------------------
  // straps are caught at the start of each interval, never mid-count
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      sel_q <= 3'h0;
    else if (state_q == pgit_pkg::PGIT_ST_COUNT && cnt_q == '0)
      sel_q <= {INTERVAL_SELECT_BIT2, INTERVAL_SELECT_BIT1, INTERVAL_SELECT_BIT0};
  end

  // strap code to oscillator periods
  always_comb
  begin
    case (sel_q)
      3'h0: periods = `PGIT_PERIODS_16S;
      3'h1: periods = `PGIT_PERIODS_32S;
      3'h2: periods = `PGIT_PERIODS_64S;
      3'h3: periods = `PGIT_PERIODS_100S;
      3'h4: periods = `PGIT_PERIODS_128S;
      3'h5: periods = `PGIT_PERIODS_256S;
      3'h6: periods = `PGIT_PERIODS_512S;
      default: periods = `PGIT_PERIODS_1024S;
    endcase
  end

  assign target_halves = {periods, 1'b0};

  // expiry on the last half tick of the interval
  assign expire = (state_q == pgit_pkg::PGIT_ST_COUNT) && tick &&
                  (cnt_q == target_halves - (CW+1)'(1));
  assign drive_end = (state_q == pgit_pkg::PGIT_ST_DRIVE) && tick &&
                     (phase_q == `PGIT_GATE_HALVES);

  // ------------------------------------------------------------------
  // sequence state and drive phase
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      state_q <= pgit_pkg::PGIT_ST_COUNT;
      phase_q <= 2'h0;
    end
    else if (done_evt)
    begin
      state_q <= pgit_pkg::PGIT_ST_COUNT;
      phase_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        pgit_pkg::PGIT_ST_COUNT:
        begin
          if (expire)
          begin
            state_q <= pgit_pkg::PGIT_ST_DRIVE;
            phase_q <= 2'h0;
          end
        end
        default:
        begin
          if (drive_end)
            state_q <= pgit_pkg::PGIT_ST_COUNT;
          else if (tick)
            phase_q <= phase_q + 2'h1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // interval counter in half periods
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      cnt_q <= '0;
    else if (done_evt || expire)
      cnt_q <= '0;
    else if (state_q == pgit_pkg::PGIT_ST_COUNT && tick)
      cnt_q <= cnt_q + (CW+1)'(1);
  end

  // ------------------------------------------------------------------
  // power gate drive
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      gate_q <= `PGIT_GATE_RESET;
    else if (done_evt)
      gate_q <= 1'b1;
    else if (expire)
      gate_q <= 1'b0;
    else if (drive_end)
      gate_q <= 1'b1;
  end

  // ------------------------------------------------------------------
  // calibration pulse
  // ------------------------------------------------------------------
  // one period wide, starting one half tick after the gate falls
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      cal_q <= `PGIT_CAL_RESET;
    else if (done_evt)
      cal_q <= 1'b0;
    else if (state_q == pgit_pkg::PGIT_ST_DRIVE && tick)
    begin
      if (phase_q == `PGIT_CAL_START_HALVES - 2'h1)
        cal_q <= 1'b1;
      else if (phase_q == `PGIT_CAL_END_HALVES - 2'h1)
        cal_q <= 1'b0;
    end
  end

  assign POWER_GATE_DRIVE_N = gate_q;
  assign CALIBRATION_PULSE_OUT = cal_q;

  // ------------------------------------------------------------------
  // assertion helpers
  // ------------------------------------------------------------------
  localparam logic [39:0] HALF40 = 40'(HALF_CYCLES);
  logic [39:0] since_start_q;
  logic [39:0] since_fall_q;

  // cycles since the interval began
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      since_start_q <= 40'h0;
    else if (done_evt || drive_end)
      since_start_q <= 40'h0;
    else
      since_start_q <= since_start_q + 40'h1;
  end

  // cycles since the gate drive fell
  always_ff @(posedge CLOCK or negedge rst_n_int)
  begin
    if (!rst_n_int)
      since_fall_q <= 40'h0;
    else if (expire)
      since_fall_q <= 40'h0;
    else
      since_fall_q <= since_fall_q + 40'h1;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_gate_off_unpowered: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    !SUPPLY_GOOD_IN |-> POWER_GATE_DRIVE_N && cnt_q == '0)
    else $error("gate drive or counter active with supply low");

  a_cal_low_unpowered: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    !SUPPLY_GOOD_IN |-> !CALIBRATION_PULSE_OUT && state_q == pgit_pkg::PGIT_ST_COUNT)
    else $error("calibration high or sequence alive with supply low");

  a_supply_drop_off: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $fell(SUPPLY_GOOD_IN) && !$past(POWER_GATE_DRIVE_N) |-> POWER_GATE_DRIVE_N)
    else $error("host still powered after supply drop");

  a_start_on_rise: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $rose(SUPPLY_GOOD_IN) |-> state_q == pgit_pkg::PGIT_ST_COUNT && cnt_q == '0 &&
      POWER_GATE_DRIVE_N ##1 since_start_q == 40'h1)
    else $error("count did not start on supply rise");

  a_interval_exact: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    $fell(POWER_GATE_DRIVE_N) |-> since_start_q == 40'(target_halves) * HALF40)
    else $error("gate drive fell before or after the full interval");

  a_cal_rise_half: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    $rose(CALIBRATION_PULSE_OUT) |-> !POWER_GATE_DRIVE_N && since_fall_q == HALF40)
    else $error("calibration did not rise half a period after gate fall");

  a_cal_width_one: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    $fell(CALIBRATION_PULSE_OUT) && !$past(done_evt) |-> since_fall_q == 3 * HALF40)
    else $error("calibration width is not one oscillator period");

  a_gate_two_periods: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    $rose(POWER_GATE_DRIVE_N) && !$past(done_evt) |-> since_fall_q == 4 * HALF40)
    else $error("gate drive low time is not two oscillator periods");

  a_done_clears: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    done_evt |=> POWER_GATE_DRIVE_N && !CALIBRATION_PULSE_OUT && cnt_q == '0 &&
      state_q == pgit_pkg::PGIT_ST_COUNT)
    else $error("done did not restore defaults and clear the count");

  a_done_cuts_cal: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    done_evt && CALIBRATION_PULSE_OUT |=> !CALIBRATION_PULSE_OUT ##1 !CALIBRATION_PULSE_OUT)
    else $error("calibration not cut short by done");

  a_gate_then_cal: assert property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    $fell(POWER_GATE_DRIVE_N) |-> !CALIBRATION_PULSE_OUT)
    else $error("calibration high when gate drive fell");

  c_natural_end: cover property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    drive_end && !done_evt);

  c_done_in_drive: cover property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    done_evt && !POWER_GATE_DRIVE_N && !CALIBRATION_PULSE_OUT);

  c_done_during_cal: cover property (
    @(posedge CLOCK) disable iff (!rst_n_int)
    done_evt && CALIBRATION_PULSE_OUT);

  c_supply_drop_on: cover property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $fell(SUPPLY_GOOD_IN) && !$past(POWER_GATE_DRIVE_N));
endmodule : pgit_top

// ==== sim/pgit_host_model.sv ====
// host model: answers power-up with done and times the calibration pulse
module pgit_host_model (
  input wire logic clk, // system clock
  input wire logic gate_n, // power gate drive seen by the host
  input wire logic cal, // calibration pulse from the timer
  input wire logic en, // host answers with done
  input wire logic [31:0] dly, // powered cycles before done, at least 1
  input wire logic [31:0] factor, // interval factor of the chosen code
  output logic done, // one-cycle done pulse
  output int est // measured pulse width times factor
);
  timeunit 1ns;
  timeprecision 100ps;
  int on_cnt;
  int cal_cnt;

  // sampled just after each edge, like a host polling its pins
  initial
  begin
    done = 1'b0;
    est = 0;
    on_cnt = 0;
    cal_cnt = 0;
    forever
    begin
      @(posedge clk);
      #1;
      on_cnt = (gate_n === 1'b0) ? on_cnt + 1 : 0;
      done = en && on_cnt == dly;
      // width counted on the system clock, scaled when the pulse ends
      if (cal === 1'b1)
        cal_cnt++;
      else if (cal_cnt != 0)
      begin
        est = cal_cnt * factor;
        cal_cnt = 0;
      end
    end
  end
endmodule : pgit_host_model

// ==== sim/pgit_top_tb.sv ====
// self-checking bench for the power gating interval timer
module pgit_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // one-cycle half period keeps every interval short
  localparam int H = 1;
  localparam int LIMIT = 100000;
  localparam int SEC[8] = '{16, 32, 64, 100, 128, 256, 512, 1024};
  logic CLOCK, RESET_N, SUPPLY_GOOD_IN, DONE_IN;
  logic INTERVAL_SELECT_BIT0, INTERVAL_SELECT_BIT1, INTERVAL_SELECT_BIT2;
  logic POWER_GATE_DRIVE_N, CALIBRATION_PULSE_OUT;
  logic host_en;
  int host_dly, host_factor, host_est, n_fail, total_checks;

  pgit_top #(.HALF_CYCLES(H)) i_dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .SUPPLY_GOOD_IN(SUPPLY_GOOD_IN), .DONE_IN(DONE_IN),
    .INTERVAL_SELECT_BIT0(INTERVAL_SELECT_BIT0), .INTERVAL_SELECT_BIT1(INTERVAL_SELECT_BIT1),
    .INTERVAL_SELECT_BIT2(INTERVAL_SELECT_BIT2), .POWER_GATE_DRIVE_N(POWER_GATE_DRIVE_N),
    .CALIBRATION_PULSE_OUT(CALIBRATION_PULSE_OUT));
  pgit_host_model i_host (
    .clk(CLOCK), .gate_n(POWER_GATE_DRIVE_N), .cal(CALIBRATION_PULSE_OUT), .en(host_en),
    .dly(host_dly), .factor(host_factor), .done(DONE_IN), .est(host_est));

  // ------------------------------------------------------------------
  // compare helpers
  // ------------------------------------------------------------------
  // 1024 periods make 16 s, two halves to a period
  function automatic int n_of(input int code);
    return 2 * SEC[code] * 64 * H;
  endfunction : n_of
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_int(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_int
  task automatic outs(input string what, input logic g, input logic c);
    chk_bit({what, " gate"}, g, POWER_GATE_DRIVE_N);
    chk_bit({what, " cal"}, c, CALIBRATION_PULSE_OUT);
  endtask : outs

  // ------------------------------------------------------------------
  // stimulus helpers
  // ------------------------------------------------------------------
  // supply drop must clear without waiting for an edge
  task automatic supply_blip();
    @(posedge CLOCK);
    #1;
    SUPPLY_GOOD_IN = 1'b0;
    #1;
    outs("supply dropped", 1'b1, 1'b0);
    repeat (2) @(posedge CLOCK);
    #1;
    outs("supply held low", 1'b1, 1'b0);
    SUPPLY_GOOD_IN = 1'b1;
  endtask : supply_blip
  task automatic restart(input int code);
    {INTERVAL_SELECT_BIT2, INTERVAL_SELECT_BIT1, INTERVAL_SELECT_BIT0} = code[2:0];
    host_factor = SEC[code] * 64;
    supply_blip();
  endtask : restart
  task automatic wait_fall(input int lim, output int c);
    c = 0;
    while (POWER_GATE_DRIVE_N !== 1'b0 && c < lim)
    begin
      @(posedge CLOCK);
      #1;
      c++;
    end
  endtask : wait_fall
  task automatic chk_pulse();
    for (int k = 1; k <= 4 * H; k++)
    begin
      @(posedge CLOCK);
      #1;
      outs("pulse", k >= 4 * H, k >= H && k < 3 * H);
    end
  endtask : chk_pulse

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_intervals();
    int c;
    for (int code = 0; code < 5; code++)
    begin
      restart(code);
      wait_fall(n_of(code) + 8, c);
      chk_int("release to fall", n_of(code), c);
      chk_pulse();
      chk_int("host estimate", n_of(code), host_est);
    end
  endtask : t_intervals
  task automatic t_long_codes();
    int c;
    for (int code = 5; code < 8; code++)
    begin
      restart(code);
      wait_fall(n_of(1) + 8, c);
      chk_int("long code no fall", n_of(1) + 8, c);
    end
  endtask : t_long_codes
  // straps moved after the interval began only count from the next one
  task automatic t_free_run();
    int c;
    restart(0);
    @(posedge CLOCK);
    #1;
    {INTERVAL_SELECT_BIT2, INTERVAL_SELECT_BIT1, INTERVAL_SELECT_BIT0} = 3'h1;
    wait_fall(n_of(0) + 8, c);
    chk_int("straps held mid-count", n_of(0) - 1, c);
    chk_pulse();
    wait_fall(n_of(1) + 8, c);
    chk_int("rise to next fall", n_of(1), c);
  endtask : t_free_run
  task automatic t_done(input int dly);
    int c;
    host_dly = dly;
    host_en = 1'b1;
    restart(0);
    wait_fall(n_of(0) + 8, c);
    repeat (dly) @(posedge CLOCK);
    #1;
    // host silenced here so the next fall is left unanswered, no race
    host_en = 1'b0;
    outs("after done", 1'b1, 1'b0);
    wait_fall(n_of(0) + 8, c);
    chk_int("done to next fall", n_of(0), c);
  endtask : t_done
  task automatic t_supply_on();
    int c;
    restart(0);
    wait_fall(n_of(0) + 8, c);
    supply_blip();
    wait_fall(n_of(0) + 8, c);
    chk_int("supply back to fall", n_of(0), c);
  endtask : t_supply_on
  task automatic t_supply_off();
    int c;
    restart(0);
    repeat (n_of(0) / 2) @(posedge CLOCK);
    supply_blip();
    wait_fall(n_of(0) + 8, c);
    chk_int("count cleared by drop", n_of(0), c);
  endtask : t_supply_off

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // free-running system clock
  initial
  begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  // a hang counts as a mismatch and still reaches the report
  initial
  begin
    repeat (LIMIT) @(posedge CLOCK);
    n_fail++;
    $display("[ERR] cycle limit expected under %0d seen %0d", LIMIT, LIMIT);
    wrap_up();
  end
  // main sequence
  initial
  begin
    RESET_N = 1'b0;
    SUPPLY_GOOD_IN = 1'b1;
    {INTERVAL_SELECT_BIT2, INTERVAL_SELECT_BIT1, INTERVAL_SELECT_BIT0} = 3'h0;
    host_en = 1'b0;
    host_dly = 1;
    host_factor = 1024;
    n_fail = 0;
    total_checks = 0;
    repeat (12) @(posedge CLOCK);
    #1;
    outs("in reset", 1'b1, 1'b0);
    RESET_N = 1'b1;
    @(posedge CLOCK);
    #1;
    outs("first edge", 1'b1, 1'b0);
    t_intervals();
    t_long_codes();
    t_free_run();
    t_done(1);
    t_done(2);
    t_supply_on();
    t_supply_off();
    wrap_up();
  end
endmodule : pgit_top_tb
